/* File: verilog/self_test_pkg.sv */
// Purpose: shared constants and types for the boot self-test sequencer
// Assumes: single clock, register port with one-cycle read latency
// Notes: register offsets are word indices on the plain register port
package self_test_pkg;

  // ==========================================================
  // sizes
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int GRP_W = 32;

  // ==========================================================
  // register offsets
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_LOGIC_CFG = 6'h01;
  localparam logic [5:0] OFF_MEM_CFG_LOW = 6'h02;
  localparam logic [5:0] OFF_MEM_CFG_MID = 6'h03;
  localparam logic [5:0] OFF_MEM_CFG_HIGH = 6'h04;
  localparam logic [5:0] OFF_RUN_STAT = 6'h05;
  localparam logic [5:0] OFF_OFFLINE_LOGIC_FAIL = 6'h08;
  localparam logic [5:0] OFF_OFFLINE_LOGIC_UNFIN = 6'h09;
  localparam logic [5:0] OFF_OFFLINE_MEM_FAIL = 6'h0a; // +0 low +1 mid +2 high
  localparam logic [5:0] OFF_OFFLINE_MEM_UNFIN = 6'h0d;
  localparam logic [5:0] OFF_ONLINE_LOGIC_FAIL = 6'h10;
  localparam logic [5:0] OFF_ONLINE_LOGIC_UNFIN = 6'h11;
  localparam logic [5:0] OFF_ONLINE_MEM_FAIL = 6'h12;
  localparam logic [5:0] OFF_ONLINE_MEM_UNFIN = 6'h15;
  localparam logic [5:0] OFF_INTERNAL_ERR = 6'h18;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h19;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h1a;

  // ==========================================================
  // reset values and bit positions
  localparam logic [31:0] CFG_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int CTRL_BOOT_DIS = 0;
  localparam int CTRL_START = 1; // self-clearing, shutdown run
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_ERR = 2;
  localparam int ERR_TIMEOUT = 0;
  localparam int ERR_START_BUSY = 1;

  // ==========================================================
  // timing: partition watchdog and detector self-test
  localparam int CLK_MHZ = 25;
  localparam int PART_TIMEOUT_US = 100;
  localparam int PART_TIMEOUT_CYC = PART_TIMEOUT_US * CLK_MHZ;
  localparam int VD_TEST_NS = 400;
  localparam int VD_TEST_CYC = (VD_TEST_NS + 39) / 40;

  typedef enum {
    ST_IDLE, ST_VD_TEST, ST_LOGIC, ST_MEM, ST_DECIDE, ST_RESET, ST_HALT
  } seq_state_t;

  // a partition run handed to the engines
  typedef struct packed {
    logic is_mem;
    logic [6:0] index;
  } part_req_t;

  // an engine answer
  typedef struct packed {
    logic done;
    logic fail;
    logic uncorrectable;
  } part_ans_t;

endpackage : self_test_pkg

/* File: verilog/result_bank.sv */
// Purpose: one set of fail and unfinished bits for a test group
// Assumes: record and clear never asked for the same bit at once by sw
// Notes: unfinished bits preset on arm, cleared as each partition ends
module result_bank #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic arm,
  input wire logic [W-1:0] armed_mask,
  input wire logic rec,
  input wire logic [$clog2(W)-1:0] rec_idx,
  input wire logic rec_fail,
  output logic [W-1:0] fail_r,
  output logic [W-1:0] unfin_r
);
  import self_test_pkg::*;

  logic [W-1:0] fail_nxt;
  logic [W-1:0] unfin_nxt;

  // ==========================================================
  // arm presets unfinished; each partition result lands in its bit
  always_comb begin
    fail_nxt = fail_r;
    unfin_nxt = unfin_r;
    if (arm) begin
      fail_nxt = '0;
      unfin_nxt = armed_mask;
    end
    if (rec) begin
      fail_nxt[rec_idx] = rec_fail;
      unfin_nxt[rec_idx] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fail_r <= '0;
      unfin_r <= '0;
    end else begin
      fail_r <= fail_nxt;
      unfin_r <= unfin_nxt;
    end
  end

endmodule : result_bank

/* File: verilog/boot_self_test_sequencer.sv */
// Purpose: runs logic and memory self-test partitions at boot or on demand
// Assumes: engines answer each request with one done pulse
// Notes: chip reset request and run block stay until the reset lands
// What this block does
// - start after power-on, external or destructive reset, or software start
// - logic failure or uncorrectable memory failure blocks execution
// - separate offline/online fail and unfinished status, plus internal error
// - boot tests run unless disabled, before application runs
// - boot failure keeps the device in safe state
// - scan logic test and ram/rom memory test, flash excluded
// - run without logic or uncorrectable memory failure is followed by a device reset
// - software may configure and trigger tests at shutdown
// - voltage detector tests run at start, detectors held off until done
module boot_self_test_sequencer #(
  parameter int LOGIC_PARTS = 32,
  parameter int MEM_PARTS = 96,
  parameter int TIMEOUT_CYC = self_test_pkg::PART_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic boot_reset_cause,
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output self_test_pkg::part_req_t part_req,
  output logic part_go,
  input wire self_test_pkg::part_ans_t part_ans,
  input wire logic vd_test_done,
  output logic vd_enable,
  output logic run_block,
  output logic chip_reset_req,
  output logic irq
);
  import self_test_pkg::*;

  localparam int LI_W = $clog2(LOGIC_PARTS);
  localparam int MI_W = 7;

  // ==========================================================
  // sequencer state
  seq_state_t st_r, st_nxt;
  logic online_r, online_nxt;
  logic [6:0] idx_r, idx_nxt;
  logic busy_r, busy_nxt;
  logic [31:0] tmo_r, tmo_nxt;
  logic boot_dis_r, boot_dis_nxt;
  logic boot_seen_r, boot_seen_nxt;
  logic [31:0] lcfg_r, lcfg_nxt;
  logic [MEM_PARTS-1:0] mcfg_r, mcfg_nxt;
  logic [1:0] err_r, err_nxt;
  logic [2:0] ist_r, ist_nxt;
  logic [2:0] imask_r, imask_nxt;
  logic uncorr_r, uncorr_nxt;
  logic [31:0] rdata_nxt;
  logic vd_en_r, vd_en_nxt;

  logic start_sw, arm_off, arm_on, rec_l, rec_m, last_l, last_m;
  logic rec_fail;
  logic [2:0] ev;
  logic [LOGIC_PARTS-1:0] lf_off, lu_off, lf_on, lu_on;
  logic [MEM_PARTS-1:0] mf_off, mu_off, mf_on, mu_on;

  assign start_sw = wr && addr == OFF_CTRL && wdata[CTRL_START];
  assign rec_fail = part_ans.fail || tmo_r == 32'h0000_0001;

  // ==========================================================
  // four result groups, offline and online kept apart
  result_bank #(.W(LOGIC_PARTS)) u_lg_off (.clk(clk), .nrst(nrst),
    .arm(arm_off), .armed_mask(lcfg_r[LOGIC_PARTS-1:0]),
    .rec(rec_l && !online_r), .rec_idx(idx_r[LI_W-1:0]),
    .rec_fail(rec_fail), .fail_r(lf_off), .unfin_r(lu_off));
  result_bank #(.W(LOGIC_PARTS)) u_lg_on (.clk(clk), .nrst(nrst),
    .arm(arm_on), .armed_mask(lcfg_r[LOGIC_PARTS-1:0]),
    .rec(rec_l && online_r), .rec_idx(idx_r[LI_W-1:0]),
    .rec_fail(rec_fail), .fail_r(lf_on), .unfin_r(lu_on));
  result_bank #(.W(MEM_PARTS)) u_mm_off (.clk(clk), .nrst(nrst),
    .arm(arm_off), .armed_mask(mcfg_r),
    .rec(rec_m && !online_r), .rec_idx(idx_r[MI_W-1:0]),
    .rec_fail(rec_fail), .fail_r(mf_off), .unfin_r(mu_off));
  result_bank #(.W(MEM_PARTS)) u_mm_on (.clk(clk), .nrst(nrst),
    .arm(arm_on), .armed_mask(mcfg_r),
    .rec(rec_m && online_r), .rec_idx(idx_r[MI_W-1:0]),
    .rec_fail(rec_fail), .fail_r(mf_on), .unfin_r(mu_on));

  // ==========================================================
  // partition walk: logic first, then memory, one at a time
  always_comb begin
    st_nxt = st_r;
    online_nxt = online_r;
    idx_nxt = idx_r;
    busy_nxt = busy_r;
    tmo_nxt = tmo_r;
    uncorr_nxt = uncorr_r;
    vd_en_nxt = vd_en_r;
    boot_seen_nxt = boot_seen_r;
    arm_off = 1'b0;
    arm_on = 1'b0;
    rec_l = 1'b0;
    rec_m = 1'b0;
    ev = 3'b000;
    last_l = idx_r == 7'(LOGIC_PARTS - 1);
    last_m = idx_r == 7'(MEM_PARTS - 1);
    case (st_r)
      ST_IDLE: begin
        if (boot_reset_cause && !boot_seen_r) begin
          boot_seen_nxt = 1'b1; // one boot run per reset cause
          st_nxt = ST_VD_TEST;
        end else if (start_sw) begin
          online_nxt = 1'b1; // shutdown run as configured
          arm_on = 1'b1;
          idx_nxt = 7'd0;
          uncorr_nxt = 1'b0;
          st_nxt = ST_LOGIC;
        end
      end
      ST_VD_TEST: begin
        if (vd_test_done) begin
          vd_en_nxt = 1'b1; // detectors only after their own
          if (boot_dis_r) begin
            st_nxt = ST_IDLE; // boot tests disabled
          end else begin
            online_nxt = 1'b0; // automatic boot run
            arm_off = 1'b1;
            idx_nxt = 7'd0;
            uncorr_nxt = 1'b0;
            st_nxt = ST_LOGIC;
          end
        end
      end
      ST_LOGIC, ST_MEM: begin
        if (!busy_r) begin
          if ((st_r == ST_LOGIC ? lcfg_r[idx_r[4:0]] : mcfg_r[idx_r])) begin
            busy_nxt = 1'b1;
            tmo_nxt = 32'(TIMEOUT_CYC);
          end else begin
            if (st_r == ST_LOGIC && last_l) begin
              st_nxt = ST_MEM;
              idx_nxt = 7'd0;
            end else if (st_r == ST_MEM && last_m) begin
              st_nxt = ST_DECIDE;
            end else begin
              idx_nxt = idx_r + 7'd1;
            end
          end
        end else begin
          tmo_nxt = tmo_r - 32'h0000_0001;
          if (part_ans.done || tmo_r == 32'h0000_0001) begin
            busy_nxt = 1'b0;
            rec_l = st_r == ST_LOGIC; // record before moving on
            rec_m = st_r == ST_MEM;
            // answer bits mean nothing without done, a timeout must not
            // be mistaken for an uncorrectable memory failure
            if (st_r == ST_MEM && part_ans.done && part_ans.fail
                && part_ans.uncorrectable)
              uncorr_nxt = 1'b1;
            if (tmo_r == 32'h0000_0001)
              ev[IRQ_ERR] = 1'b1;
            if (st_r == ST_LOGIC && last_l) begin
              st_nxt = ST_MEM;
              idx_nxt = 7'd0;
            end else if (st_r == ST_MEM && last_m) begin
              st_nxt = ST_DECIDE;
            end else begin
              idx_nxt = idx_r + 7'd1;
            end
          end
        end
      end
      ST_DECIDE: begin
        ev[IRQ_DONE] = 1'b1;
        // logic or uncorrectable memory failure blocks the device
        if (|(online_r ? lf_on : lf_off) || uncorr_r) begin
          ev[IRQ_FAIL] = 1'b1;
          st_nxt = ST_HALT;
        end else begin
          st_nxt = ST_RESET; // correctable-only left to software
        end
      end
      ST_RESET: st_nxt = ST_RESET; // held until chip reset lands
      ST_HALT: st_nxt = ST_HALT; // safe state, only reset leaves
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      online_r <= 1'b0;
      idx_r <= 7'd0;
      busy_r <= 1'b0;
      tmo_r <= 32'h0000_0000;
      uncorr_r <= 1'b0;
      vd_en_r <= 1'b0;
      boot_seen_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      online_r <= online_nxt;
      idx_r <= idx_nxt;
      busy_r <= busy_nxt;
      tmo_r <= tmo_nxt;
      uncorr_r <= uncorr_nxt;
      vd_en_r <= vd_en_nxt;
      boot_seen_r <= boot_seen_nxt;
    end
  end

  // ==========================================================
  // outputs to engines and reset logic
  assign part_go = (st_r == ST_LOGIC || st_r == ST_MEM) && busy_nxt
    && !busy_r;
  assign part_req = '{is_mem: st_r == ST_MEM, index: idx_r};
  // application held off during any run and in safe state
  assign run_block = st_r != ST_IDLE;
  assign chip_reset_req = st_r == ST_RESET;
  assign vd_enable = vd_en_r;

  // ==========================================================
  // config, error and interrupt registers; set beats clear
  always_comb begin
    boot_dis_nxt = boot_dis_r;
    lcfg_nxt = lcfg_r;
    mcfg_nxt = mcfg_r;
    imask_nxt = imask_r;
    err_nxt = err_r;
    ist_nxt = ist_r;
    if (wr && (st_r == ST_IDLE || st_r == ST_VD_TEST)) begin
      // open during detector test so boot disable can still land
      if (addr == OFF_CTRL) boot_dis_nxt = wdata[CTRL_BOOT_DIS];
      if (addr == OFF_LOGIC_CFG) lcfg_nxt = wdata;
      if (addr == OFF_MEM_CFG_LOW) mcfg_nxt[31:0] = wdata;
      if (addr == OFF_MEM_CFG_MID) mcfg_nxt[63:32] = wdata;
      if (addr == OFF_MEM_CFG_HIGH) mcfg_nxt[95:64] = wdata;
    end
    if (wr && addr == OFF_IRQ_MASK) imask_nxt = wdata[2:0];
    if (wr && addr == OFF_INTERNAL_ERR) err_nxt = err_r & ~wdata[1:0];
    if (wr && addr == OFF_IRQ_STAT) ist_nxt = ist_r & ~wdata[2:0];
    if (tmo_r == 32'h0000_0001 && busy_r) err_nxt[ERR_TIMEOUT] = 1'b1;
    if (start_sw && st_r != ST_IDLE) begin
      err_nxt[ERR_START_BUSY] = 1'b1; // sequencer self error
      ist_nxt[IRQ_ERR] = 1'b1;
    end
    ist_nxt = ist_nxt | ev;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_dis_r <= 1'b0;
      lcfg_r <= CFG_RESET;
      mcfg_r <= {MEM_PARTS{1'b1}};
      imask_r <= 3'b000;
      err_r <= 2'b00;
      ist_r <= 3'b000;
    end else begin
      boot_dis_r <= boot_dis_nxt;
      lcfg_r <= lcfg_nxt;
      mcfg_r <= mcfg_nxt;
      imask_r <= imask_nxt;
      err_r <= err_nxt;
      ist_r <= ist_nxt;
    end
  end

  assign irq = |(ist_r & imask_r);

  // ==========================================================
  // read mux, data one cycle after the strobe
  always_comb begin
    rdata_nxt = ZERO_WORD;
    if (rd) begin
      case (addr)
        OFF_CTRL: rdata_nxt = {31'd0, boot_dis_r};
        OFF_LOGIC_CFG: rdata_nxt = lcfg_r;
        OFF_MEM_CFG_LOW: rdata_nxt = mcfg_r[31:0];
        OFF_MEM_CFG_MID: rdata_nxt = mcfg_r[63:32];
        OFF_MEM_CFG_HIGH: rdata_nxt = mcfg_r[95:64];
        OFF_RUN_STAT: rdata_nxt = {29'd0, st_r == ST_HALT, online_r,
          run_block};
        OFF_OFFLINE_LOGIC_FAIL: rdata_nxt = lf_off;
        OFF_OFFLINE_LOGIC_UNFIN: rdata_nxt = lu_off;
        6'h0a: rdata_nxt = mf_off[31:0];
        6'h0b: rdata_nxt = mf_off[63:32];
        6'h0c: rdata_nxt = mf_off[95:64];
        6'h0d: rdata_nxt = mu_off[31:0];
        6'h0e: rdata_nxt = mu_off[63:32];
        6'h0f: rdata_nxt = mu_off[95:64];
        OFF_ONLINE_LOGIC_FAIL: rdata_nxt = lf_on;
        OFF_ONLINE_LOGIC_UNFIN: rdata_nxt = lu_on;
        6'h12: rdata_nxt = mf_on[31:0];
        6'h13: rdata_nxt = mf_on[63:32];
        6'h14: rdata_nxt = mf_on[95:64];
        6'h15: rdata_nxt = mu_on[31:0];
        6'h16: rdata_nxt = mu_on[63:32];
        6'h17: rdata_nxt = mu_on[95:64];
        OFF_INTERNAL_ERR: rdata_nxt = {30'd0, err_r};
        OFF_IRQ_STAT: rdata_nxt = {29'd0, ist_r};
        OFF_IRQ_MASK: rdata_nxt = {29'd0, imask_r};
        default: rdata_nxt = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdata <= ZERO_WORD;
    else rdata <= rdata_nxt;
  end

  // ==========================================================
  // checks
  halt_on_fail_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == ST_DECIDE && uncorr_r) |=> st_r == ST_HALT)
    else $error("uncorrectable memory failure did not halt");
  halt_holds_a: assert property (@(posedge clk) disable iff (!nrst)
    st_r == ST_HALT |=> st_r == ST_HALT && run_block && !chip_reset_req)
    else $error("safe state left");
  reset_after_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == ST_DECIDE && !uncorr_r && !(|(online_r ? lf_on : lf_off)))
    |=> chip_reset_req)
    else $error("no reset after completed run");
  vd_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == ST_VD_TEST && !vd_test_done) |=> !vd_enable)
    else $error("detectors enabled before their test");
  boot_start_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == ST_IDLE && boot_reset_cause && !boot_seen_r)
    |=> st_r == ST_VD_TEST)
    else $error("boot run not started");
  sw_start_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == ST_IDLE && start_sw && !(boot_reset_cause && !boot_seen_r))
    |=> st_r == ST_LOGIC && online_r)
    else $error("software run not started");
  one_at_time_a: assert property (@(posedge clk) disable iff (!nrst)
    part_go |=> busy_r ##0 !part_go)
    else $error("second partition started while busy");
  run_blocks_a: assert property (@(posedge clk) disable iff (!nrst)
    (run_block && !(st_r == ST_VD_TEST && vd_test_done && boot_dis_r))
    |=> run_block)
    else $error("application released during a run");
  err_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
    (start_sw && st_r != ST_IDLE) |=> err_r[ERR_START_BUSY] && ist_r[IRQ_ERR])
    else $error("internal error not recorded");
  cfg_part_a: assert property (@(posedge clk) disable iff (!nrst)
    part_go |-> (part_req.is_mem ? mcfg_r[part_req.index]
      : lcfg_r[part_req.index[4:0]]))
    else $error("disabled partition started");

endmodule : boot_self_test_sequencer

/* File: testbench/test_engine_model.sv */
// Purpose: behavioural partition engines and voltage detector self-test
// Assumes: one partition in flight at a time, answered by one done pulse
// Notes: answer bits toggle outside done so stale values never look valid
module test_engine_model #(
  parameter int VD_CYC = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire self_test_pkg::part_req_t part_req,
  input wire logic part_go,
  input wire logic fail_en,
  input wire logic mute,
  input wire logic uncorr,
  input wire self_test_pkg::part_req_t fail_req,
  output self_test_pkg::part_ans_t part_ans,
  output logic vd_test_done
);
  timeunit 1ns;
  timeprecision 1ns;
  import self_test_pkg::*;

  part_req_t cur;
  logic busy;
  logic hit;
  int wait_c;
  int vd_c;

  assign hit = fail_en && (cur == fail_req);

  // ==========================================================
  // engines
  // random delay per partition so slow and prompt answers both occur
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      cur <= '0;
      wait_c <= 0;
      vd_c <= 0;
      vd_test_done <= 1'b0;
      part_ans <= '0;
    end else begin
      vd_c <= (vd_c < VD_CYC) ? vd_c + 1 : vd_c;
      vd_test_done <= (vd_c >= VD_CYC);
      if (part_go) begin
        busy <= 1'b1;
        cur <= part_req;
        wait_c <= $urandom_range(4, 1);
      end else if (busy && wait_c > 1) begin
        wait_c <= wait_c - 1;
      end else if (busy && !(mute && hit)) begin
        // muted partition never answers, the watchdog must catch it
        busy <= 1'b0;
      end
      // one answer assignment per edge, done only as the wait runs out
      if (!part_go && busy && wait_c <= 1 && !(mute && hit))
        part_ans <= '{1'b1, hit, hit && uncorr};
      else
        part_ans <= '{1'b0, ~part_ans.fail, ~part_ans.uncorrectable};
    end
  end
endmodule : test_engine_model

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the boot self-test sequencer
// Assumes: partition watchdog shortened to 20 cycles
// Notes: expected partition order kept in a queue, results in vectors
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import self_test_pkg::*;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic boot_reset_cause = 1'b0;
  logic [5:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fail_en = 1'b0;
  logic mute = 1'b0;
  logic uncorr = 1'b0;
  logic boot_run = 1'b0;
  part_req_t fail_req = '0;
  logic [31:0] rdata;
  part_req_t part_req;
  part_ans_t part_ans;
  logic part_go, vd_test_done, vd_enable, run_block, chip_reset_req, irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  part_req_t exp_q[$];

  always #20 clk = ~clk;

  boot_self_test_sequencer #(.TIMEOUT_CYC(20)) boot_self_test_sequencer_inst (
    .clk(clk), .nrst(nrst), .boot_reset_cause(boot_reset_cause),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .part_req(part_req), .part_go(part_go), .part_ans(part_ans),
    .vd_test_done(vd_test_done), .vd_enable(vd_enable),
    .run_block(run_block), .chip_reset_req(chip_reset_req), .irq(irq));

  test_engine_model test_engine_model_inst (
    .clk(clk), .nrst(nrst), .part_req(part_req), .part_go(part_go),
    .fail_en(fail_en), .mute(mute), .uncorr(uncorr), .fail_req(fail_req),
    .part_ans(part_ans), .vd_test_done(vd_test_done));

  // ==========================================================
  // closing report and hang guard
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // every partition start is checked against the expected order
  always @(posedge clk) begin
    if (nrst === 1'b1 && part_go === 1'b1) begin
      `CHK("go expected", 1'b1, exp_q.size() != 0)
      if (exp_q.size() != 0) begin
        `CHK("partition", exp_q[0], part_req)
        void'(exp_q.pop_front());
      end
      if (boot_run)
        `CHK("vd test first", 1'b1, vd_test_done)
    end
  end

  // ==========================================================
  // register port and run helpers
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic start(input logic cause);
    exp_q.delete();
    nrst <= 1'b0;
    boot_reset_cause <= cause;
    boot_run <= cause;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
  endtask : start

  task automatic load(input logic [31:0] lc, input logic [95:0] mc);
    for (int i = 0; i < 32; i++)
      if (lc[i]) exp_q.push_back('{1'b0, 7'(i)});
    for (int i = 0; i < 96; i++)
      if (mc[i]) exp_q.push_back('{1'b1, 7'(i)});
  endtask : load

  // poll run status; a run ends in reset request or halt
  task automatic wait_end();
    logic [31:0] v;
    logic ended;
    ended = 1'b0;
    for (int i = 0; i < 1500; i++) begin
      rd_reg(OFF_RUN_STAT, v);
      ended = chip_reset_req === 1'b1 || v[2] === 1'b1;
      if (ended) break;
    end
    `CHK("run ended", 1'b1, ended)
  endtask : wait_end

  task automatic results(input logic [5:0] base, input logic [31:0] lf,
      input logic [95:0] mf, input logic halt, input logic full);
    logic [31:0] v;
    rd_reg(base, v);
    `CHK("logic fail", lf, v)
    for (int k = 0; k < 3; k++) begin
      rd_reg(base + 6'(2 + k), v);
      `CHK("mem fail", mf[k*32 +: 32], v)
      rd_reg(base + 6'(5 + k), v);
      if (full) `CHK("mem unfinished", ZERO_WORD, v)
    end
    rd_reg(base + 6'd1, v);
    if (full) `CHK("logic unfinished", ZERO_WORD, v)
    if (full) `CHK("queue left", 0, exp_q.size())
    rd_reg(OFF_RUN_STAT, v);
    `CHK("halted", halt, v[2])
    `CHK("chip reset", ~halt, chip_reset_req)
    `CHK("run block", 1'b1, run_block)
  endtask : results

  // ==========================================================
  // tests
  initial begin
    logic [31:0] v;
    logic [31:0] lc;
    logic [95:0] mc;
    void'($urandom(13927));
    // boot run, all partitions pass
    start(1'b1);
    load(CFG_RESET, {3{CFG_RESET}});
    repeat (8) begin
      @(posedge clk);
      #1 `CHK("vd held", 1'b0, vd_enable)
    end
    `CHK("boot run blocks", 1'b1, run_block)
    rd_reg(OFF_MEM_CFG_HIGH, v);
    `CHK("cfg reset", CFG_RESET, v)
    wait_end();
    results(OFF_OFFLINE_LOGIC_FAIL, '0, '0, 1'b0, 1'b1);
    `CHK("vd on", 1'b1, vd_enable)
    wr_reg(OFF_IRQ_MASK, ZERO_WORD);
    rd_reg(OFF_IRQ_STAT, v);
    `CHK("irq status", 32'h0000_0001, v)
    `CHK("irq masked", 1'b0, irq)
    wr_reg(OFF_IRQ_MASK, 32'h0000_0001);
    rd_reg(6'h3f, v);
    `CHK("unmapped", ZERO_WORD, v)
    `CHK("irq on", 1'b1, irq)
    wr_reg(OFF_IRQ_STAT, 32'h0000_0001);
    rd_reg(OFF_IRQ_STAT, v);
    `CHK("irq cleared", ZERO_WORD, v)
    `CHK("irq off", 1'b0, irq)
    $display("test boot_pass done");
    // boot run with one failing logic partition
    v = $urandom_range(31, 0);
    fail_req <= '{1'b0, v[6:0]};
    fail_en <= 1'b1;
    start(1'b1);
    load(CFG_RESET, {3{CFG_RESET}});
    wait_end();
    results(OFF_OFFLINE_LOGIC_FAIL, 32'h1 << v, '0, 1'b1, 1'b0);
    $display("test boot_logic_fail done");
    // boot tests disabled while the detectors test themselves
    start(1'b1);
    wr_reg(OFF_CTRL, 32'h0000_0001);
    repeat (12) @(posedge clk);
    rd_reg(OFF_RUN_STAT, v);
    `CHK("boot off idle", ZERO_WORD, v)
    `CHK("boot off vd", 1'b1, vd_enable)
    rd_reg(OFF_CTRL, v);
    `CHK("boot off bit", 32'h0000_0001, v)
    $display("test boot_disabled done");
    // online runs: correctable then uncorrectable memory failure
    mc = {32'h8000_0000, 32'h0000_0100, 32'h0000_0001};
    for (int u = 0; u < 2; u++) begin
      lc = $urandom() | 32'h8000_0001;
      fail_req <= '{1'b1, 7'd95};
      uncorr <= u[0];
      start(1'b0);
      wr_reg(OFF_LOGIC_CFG, lc);
      wr_reg(OFF_MEM_CFG_LOW, mc[31:0]);
      wr_reg(OFF_MEM_CFG_MID, mc[63:32]);
      wr_reg(OFF_MEM_CFG_HIGH, mc[95:64]);
      load(lc, mc);
      wr_reg(OFF_CTRL, 32'h0000_0002);
      wr_reg(OFF_LOGIC_CFG, ZERO_WORD);
      wr_reg(OFF_CTRL, 32'h0000_0002);
      wait_end();
      results(OFF_ONLINE_LOGIC_FAIL, '0, 96'h1 << 95, u[0], 1'b1);
      rd_reg(OFF_LOGIC_CFG, v);
      `CHK("cfg locked", lc, v)
      rd_reg(OFF_INTERNAL_ERR, v);
      `CHK("start busy", 32'h0000_0002, v)
      rd_reg(OFF_OFFLINE_MEM_FAIL + 6'd2, v);
      `CHK("offline apart", ZERO_WORD, v)
      $display("test online_mem_fail %0d done", u);
    end
    // online run with a silent logic partition
    fail_req <= '{1'b0, 7'd1};
    mute <= 1'b1;
    start(1'b0);
    wr_reg(OFF_LOGIC_CFG, 32'h0000_0006);
    wr_reg(OFF_MEM_CFG_LOW, ZERO_WORD);
    wr_reg(OFF_MEM_CFG_MID, ZERO_WORD);
    wr_reg(OFF_MEM_CFG_HIGH, ZERO_WORD);
    load(32'h0000_0006, '0);
    wr_reg(OFF_CTRL, 32'h0000_0002);
    wait_end();
    rd_reg(OFF_ONLINE_LOGIC_FAIL, v);
    `CHK("timeout fail", 1'b1, v[1])
    rd_reg(OFF_INTERNAL_ERR, v);
    `CHK("timeout err", 32'h0000_0001, v)
    $display("test online_timeout done");
    end_of_test();
  end
endmodule : tb_top
